// file: rtl/output_sync_polarity_control.sv
// sync output polarity and subcarrier lock inversion register bank
// Behaviour
// - polarity bit 7: hsync active high when 0, active low when 1
// - polarity bit 6: horizontal and vertical reference share one polarity select
// - polarity bit 5: vsync active high when 0, active low when 1
// - polarity bit 4: line-lock reference active high when 0, low when 1
// - polarity bit 3: field indicator active high when 0, low when 1
// - resample bit 6 set inverts subcarrier lock bit in realtime control output
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
module output_sync_polarity_control
  import sync_polarity_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hsync_raw,
  input wire logic vsync_raw,
  input wire logic horizontal_reference_raw,
  input wire logic vertical_reference_raw,
  input wire logic line_lock_ref_raw,
  input wire logic field_raw,
  input wire logic subcarrier_lock_flag,
  output logic hsync_out,
  output logic vsync_out,
  output logic horizontal_reference_out,
  output logic vertical_reference_out,
  output logic line_lock_ref_out,
  output logic field_out,
  output logic realtime_control_lock_out
);
  logic [7:0] sync_output_polarity_ff;
  logic [7:0] resample_control_ff;
  logic [7:0] reserved_fixed_pattern_ff;
  logic [11:0] awaddr_ff;
  logic aw_held_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic w_held_ff;
  logic do_write;
  logic wr_hit;
  logic [n_timing-1:0] raw_vec;
  logic [n_timing-1:0] inv_vec;
  logic [n_timing-1:0] lvl_vec;
  logic [7:0] rd_val;
  logic rd_hit;

  // write address and data latched independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata[7:0];
      wstrb0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_hit = (awaddr_ff[11:2] == {2'b00, sync_output_polarity_off}) ||
                  (awaddr_ff[11:2] == {2'b00, resample_control_off}) ||
                  (awaddr_ff[11:2] == {2'b00, reserved_fixed_pattern_off});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register storage; byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_output_polarity_ff <= polarity_reset;
      resample_control_ff <= resample_reset;
      reserved_fixed_pattern_ff <= reserved_reset;
    end else if (do_write && wstrb0_ff) begin
      case (awaddr_ff[11:2])
        {2'b00, sync_output_polarity_off}: sync_output_polarity_ff <= wdata_ff;
        // reserved fields stored as written; software keeps the patterns
        {2'b00, resample_control_off}: resample_control_ff <= wdata_ff;
        {2'b00, reserved_fixed_pattern_off}: reserved_fixed_pattern_ff <= wdata_ff;
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[11:2])
      {2'b00, sync_output_polarity_off}: rd_val = sync_output_polarity_ff;
      {2'b00, resample_control_off}: rd_val = resample_control_ff;
      {2'b00, reserved_fixed_pattern_off}: rd_val = reserved_fixed_pattern_ff;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_hit ? resp_okay : resp_slverr;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // timing signals: hsync, vsync, horizontal_reference_out, vref, line lock, field
  assign raw_vec = {field_raw, line_lock_ref_raw, vertical_reference_raw,
                    horizontal_reference_raw, vsync_raw, hsync_raw};
  assign inv_vec = {sync_output_polarity_ff[field_bit],
                    sync_output_polarity_ff[line_lock_bit],
                    sync_output_polarity_ff[hv_ref_bit],
                    sync_output_polarity_ff[hv_ref_bit],
                    sync_output_polarity_ff[vsync_bit],
                    sync_output_polarity_ff[hsync_bit]};

  level_apply u_level (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in(raw_vec),
    .invert(inv_vec),
    .level_out(lvl_vec)
  );

  assign hsync_out = lvl_vec[0];
  assign vsync_out = lvl_vec[1];
  assign horizontal_reference_out = lvl_vec[2];
  assign vertical_reference_out = lvl_vec[3];
  assign line_lock_ref_out = lvl_vec[4];
  assign field_out = lvl_vec[5];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      realtime_control_lock_out <= 1'b0;
    end else begin
      realtime_control_lock_out <= subcarrier_lock_flag ^ resample_control_ff[lock_invert_bit];
    end
  end

  a_hsync_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (hsync_out == ($past(hsync_raw) ^ $past(sync_output_polarity_ff[hsync_bit]))))
    else $error("hsync level wrong");
  a_hv_ref_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ((horizontal_reference_out ==
          ($past(horizontal_reference_raw) ^ $past(sync_output_polarity_ff[hv_ref_bit]))) &&
         (vertical_reference_out ==
          ($past(vertical_reference_raw) ^ $past(sync_output_polarity_ff[hv_ref_bit])))))
    else $error("reference levels wrong");
  a_vsync_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (vsync_out == ($past(vsync_raw) ^ $past(sync_output_polarity_ff[vsync_bit]))))
    else $error("vsync level wrong");
  a_line_lock_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (line_lock_ref_out ==
         ($past(line_lock_ref_raw) ^ $past(sync_output_polarity_ff[line_lock_bit]))))
    else $error("line lock level wrong");
  a_field_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (field_out == ($past(field_raw) ^ $past(sync_output_polarity_ff[field_bit]))))
    else $error("field level wrong");
  a_lock_invert: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (realtime_control_lock_out ==
         ($past(subcarrier_lock_flag) ^ $past(resample_control_ff[lock_invert_bit]))))
    else $error("lock inversion wrong");
  a_reserved_store: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wstrb0_ff && awaddr_ff[11:2] == {2'b00, reserved_fixed_pattern_off})
    |=> (reserved_fixed_pattern_ff == $past(wdata_ff)))
    else $error("reserved register not stored");
  a_bresp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");
endmodule

// file: rtl/sync_polarity_pkg.sv
// register map, field positions and reset values for the sync polarity block
package sync_polarity_pkg;
  localparam logic [7:0] sync_output_polarity_off = 8'h37;
  localparam logic [7:0] resample_control_off = 8'h44;
  localparam logic [7:0] reserved_fixed_pattern_off = 8'h45;
  // printed offsets are not all multiples of four: byte address is index times four
  localparam logic [9:0] sync_output_polarity_addr = 10'h0DC;
  localparam logic [9:0] resample_control_addr = 10'h110;
  localparam logic [9:0] reserved_fixed_pattern_addr = 10'h114;
  localparam int hsync_bit = 7;
  localparam int hv_ref_bit = 6;
  localparam int vsync_bit = 5;
  localparam int line_lock_bit = 4;
  localparam int field_bit = 3;
  localparam int lock_invert_bit = 6;
  localparam logic [7:0] polarity_reset = 8'h00;
  localparam logic [7:0] resample_reset = 8'h01;
  localparam logic [7:0] reserved_reset = 8'h23;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam int n_timing = 6;
endpackage

// file: rtl/level_apply.sv
// per-signal polarity application, registered
`timescale 1ns/100ps
module level_apply
  import sync_polarity_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [n_timing-1:0] raw_in,
  input wire logic [n_timing-1:0] invert,
  output logic [n_timing-1:0] level_out
);
  genvar gi;
  generate
    for (gi = 0; gi < n_timing; gi++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          level_out[gi] <= 1'b0;
        end else begin
          level_out[gi] <= raw_in[gi] ^ invert[gi];
        end
      end
    end
  endgenerate
endmodule

// file: dv/video_sink.sv
// downstream back-end model sampling the timing outputs
`timescale 1ns/100ps
module video_sink (
  input wire logic aclk,
  input wire logic [6:0] timing_in,
  output logic [6:0] seen
);
  // back-end registers every timing level on the pixel clock
  always_ff @(posedge aclk) begin
    seen <= timing_in;
  end
endmodule

// file: dv/tb_top.sv
// self-checking bench for the sync polarity register bank
`timescale 1ns/100ps
module tb_top;
  import sync_polarity_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, flag;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [5:0] raw;
  logic [6:0] tout, seen;
  logic [7:0] p;
  int fail_count, n_compared;

  output_sync_polarity_control u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hsync_raw(raw[5]), .vsync_raw(raw[4]), .horizontal_reference_raw(raw[3]),
    .vertical_reference_raw(raw[2]), .line_lock_ref_raw(raw[1]), .field_raw(raw[0]),
    .subcarrier_lock_flag(flag), .hsync_out(tout[6]), .vsync_out(tout[5]),
    .horizontal_reference_out(tout[4]), .vertical_reference_out(tout[3]),
    .line_lock_ref_out(tout[2]), .field_out(tout[1]), .realtime_control_lock_out(tout[0]));

  video_sink u_sink (.aclk(aclk), .timing_in(tout), .seen(seen));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge aclk);
    fail_count++;
    finish_test();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, flag} = 7'h00;
    {awaddr, araddr, wdata, raw} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr({2'h0, sync_output_polarity_addr}, rd, rs);
    chk(rd, {24'h000000, polarity_reset});
    chk({30'h0, rs}, {30'h0, resp_okay});
    rdr({2'h0, resample_control_addr}, rd, rs);
    chk(rd, {24'h000000, resample_reset});
    rdr({2'h0, reserved_fixed_pattern_addr}, rd, rs);
    chk(rd, {24'h000000, reserved_reset});
    // unmapped place answers with an error and zero data
    rdr(12'hFFC, rd, rs);
    chk({rd[31:2], rs}, {30'h0, resp_slverr});
    wr(12'hFFC, 8'h5A, rs);
    chk({30'h0, rs}, {30'h0, resp_slverr});
    // one select bit at a time, then none, over two raw patterns
    for (int k = 0; k < 6; k++) begin
      p = 8'h08 << k;
      wr({2'h0, sync_output_polarity_addr}, p, rs);
      chk({30'h0, rs}, {30'h0, resp_okay});
      for (int j = 0; j < 2; j++) begin
        raw <= j ? 6'h15 : 6'h3F;
        repeat (3) @(posedge aclk);
        chk({26'h0, seen[6:1]}, {26'h0, raw ^ {p[7], p[5], p[6], p[6], p[4], p[3]}});
      end
    end
    // lock inversion off and on, flag low and high
    for (int m = 0; m < 4; m++) begin
      wr({2'h0, resample_control_addr}, m[1] ? 8'h41 : 8'h01, rs);
      flag <= m[0];
      repeat (3) @(posedge aclk);
      chk({31'h0, seen[0]}, {31'h0, m[0] ^ m[1]});
    end
    wr({2'h0, reserved_fixed_pattern_addr}, 8'hBB, rs);
    rdr({2'h0, reserved_fixed_pattern_addr}, rd, rs);
    chk(rd, 32'h000000BB);
    // write with byte lane 0 disabled leaves the register alone
    wstrb <= 4'h0;
    wr({2'h0, sync_output_polarity_addr}, 8'hFF, rs);
    wstrb <= 4'hF;
    rdr({2'h0, sync_output_polarity_addr}, rd, rs);
    chk(rd, 32'h00000000);
    finish_test();
  end
endmodule
